// ===== rtl/port_regs_pkg.sv
package port_regs_pkg;

  // Bus geometry of the CPU memory access
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Register addresses in the CPU data space
  localparam logic [15:0] OFS_PORT0_DIRECTION = 16'hff20;
  localparam logic [15:0] OFS_PORT1_DIRECTION = 16'hff21;
  localparam logic [15:0] OFS_PORT2_DIRECTION = 16'hff22;
  localparam logic [15:0] OFS_PORT3_DIRECTION = 16'hff23;
  localparam logic [15:0] OFS_PORT5_DIRECTION = 16'hff25;
  localparam logic [15:0] OFS_PORT7_DIRECTION = 16'hff27;
  localparam logic [15:0] OFS_PORT8_DIRECTION = 16'hff28;
  localparam logic [15:0] OFS_PORT9_DIRECTION = 16'hff29;
  localparam logic [15:0] OFS_PORT2_PULLUP_ENABLE = 16'hff32;
  localparam logic [15:0] OFS_PORT3_PULLUP_ENABLE = 16'hff33;
  localparam logic [15:0] OFS_PORT7_PULLUP_ENABLE = 16'hff37;
  localparam logic [15:0] OFS_PORT01_GROUP_PULLUP = 16'hfff7;

  // Reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] PULLUP_RESET = 8'h00;

  // Implemented bits of each direction register
  localparam logic [7:0] DIR0_MASK = 8'h0f;
  localparam logic [7:0] DIR1_MASK = 8'h0f;
  localparam logic [7:0] DIR2_MASK = 8'h7f;
  localparam logic [7:0] DIR3_MASK = 8'h0f;
  localparam logic [7:0] DIR5_MASK = 8'h0f;
  localparam logic [7:0] DIR7_MASK = 8'h07;
  localparam logic [7:0] DIR8_MASK = 8'h03;
  localparam logic [7:0] DIR9_MASK = 8'hff;

  // Implemented bits of each pull-up option register
  localparam logic [7:0] GRP_PU_MASK = 8'h03;
  localparam logic [7:0] PU2_MASK = 8'h7f;
  localparam logic [7:0] PU3_MASK = 8'h0f;
  localparam logic [7:0] PU7_MASK = 8'h07;

  // Field positions in the group pull-up register
  localparam int unsigned GRP_PU_P0_BIT = 0;
  localparam int unsigned GRP_PU_P1_BIT = 1;

  // Pin counts per port
  localparam int unsigned P0_PINS = 4;
  localparam int unsigned P1_PINS = 2;
  localparam int unsigned P2_PINS = 7;
  localparam int unsigned P3_PINS = 4;
  localparam int unsigned P5_PINS = 4;
  localparam int unsigned P7_PINS = 3;
  localparam int unsigned P8_PINS = 2;
  localparam int unsigned P9_PINS = 8;

endpackage : port_regs_pkg

// ===== rtl/port_cfg_if.sv
`timescale 1ns/1ps
// Settings shared between the register file and its helpers
interface port_cfg_if;
  logic [7:0] dir0; // Port 0 direction, 1 = input
  logic [7:0] dir1; // Port 1 direction
  logic [7:0] dir2; // Port 2 direction
  logic [7:0] dir3; // Port 3 direction
  logic [7:0] dir7; // Port 7 direction
  logic [7:0] grp_pu; // Group pull-up for ports 0 and 1
  logic [7:0] opt2; // Port 2 pull-up option
  logic [7:0] opt3; // Port 3 pull-up option
  logic [7:0] opt7; // Port 7 pull-up option

  // Register file drives, helpers only look
  modport regs (output dir0, dir1, dir2, dir3, dir7, grp_pu, opt2, opt3, opt7);
  modport user (input dir0, dir1, dir2, dir3, dir7, grp_pu, opt2, opt3, opt7);
endinterface : port_cfg_if

// ===== rtl/pullup_gate.sv
`timescale 1ns/1ps
// Pull-up connect logic: option bit AND input mode
module pullup_gate
  import port_regs_pkg::*;
(
  port_cfg_if.user cfg, // Register settings
  output logic [port_regs_pkg::P0_PINS-1:0] pu_p0, // Port 0 pull-ups
  output logic [port_regs_pkg::P1_PINS-1:0] pu_p1, // Port 1 pull-ups
  output logic [port_regs_pkg::P2_PINS-1:0] pu_p2, // Port 2 pull-ups
  output logic [port_regs_pkg::P3_PINS-1:0] pu_p3, // Port 3 pull-ups
  output logic [port_regs_pkg::P7_PINS-1:0] pu_p7 // Port 7 pull-ups
);
  // Output-mode pins never get a pull-up, alternate function or not
  always_comb
  begin
    pu_p0 = {P0_PINS{cfg.grp_pu[GRP_PU_P0_BIT]}} & cfg.dir0[P0_PINS-1:0];
    pu_p1 = {P1_PINS{cfg.grp_pu[GRP_PU_P1_BIT]}} & cfg.dir1[P1_PINS-1:0];
    pu_p2 = cfg.opt2[P2_PINS-1:0] & cfg.dir2[P2_PINS-1:0];
    pu_p3 = cfg.opt3[P3_PINS-1:0] & cfg.dir3[P3_PINS-1:0];
    pu_p7 = cfg.opt7[P7_PINS-1:0] & cfg.dir7[P7_PINS-1:0];
  end
endmodule : pullup_gate

// ===== rtl/p3_change_detect.sv
`timescale 1ns/1ps
// Flags a change of driven level on port 3 output pins
module p3_change_detect
  import port_regs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, active low
  port_cfg_if.user cfg, // Register settings
  input wire logic [port_regs_pkg::P3_PINS-1:0] p3_latch, // Port 3 output latch
  output logic [port_regs_pkg::P3_PINS-1:0] irq_set // One-cycle request pulses
);
  typedef struct packed {
    logic [P3_PINS-1:0] prev_lvl; // Latch value last cycle
    logic [P3_PINS-1:0] prev_out; // Output mode last cycle
    logic [P3_PINS-1:0] irq; // Registered pulse
  } det_state_t;

  det_state_t s_ff; // Current state
  det_state_t nxt_s; // Next state

  // A pin feeds the interrupt input too, so a driven edge raises its request
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.prev_lvl = p3_latch;
    nxt_s.prev_out = ~cfg.dir3[P3_PINS-1:0];
    nxt_s.irq = ~cfg.dir3[P3_PINS-1:0] & s_ff.prev_out & (p3_latch ^ s_ff.prev_lvl);
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign irq_set = s_ff.irq;
endmodule : p3_change_detect

// ===== rtl/port_direction_pullup_regs.sv
// What this block does
// - One direction bit per pin, independent
// - Direction registers take bit and byte writes
// - Reset sets every direction register to ones
// - Zero drives pin; one turns buffer off
// - Port 3 output change raises interrupt request
// - Pull-up only with option set and input
// - Output-mode pins never get pull-ups
// - Group register: bit0 port 0, bit1 port 1
// - Reset clears all pull-up option registers
// - Pull-up bit one means used, zero unused
// - Port 2 pull-up bits 0-6 match pins
// - Port 3 pull-up bits 0-3, upper zero
// - Port 7 pull-up bits 0-2, upper zero
// - Pull-up registers take bit and byte writes
// - Port 0 group bit covers all four pins
// - Port 1 group bit covers both pins
`timescale 1ns/1ps
module port_direction_pullup_regs
  import port_regs_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic [port_regs_pkg::ADDR_W-1:0] cpu_addr, // Data-space address
  input wire logic cpu_wr, // Write strobe
  input wire logic cpu_bit_op, // 1 = single-bit access
  input wire logic [2:0] cpu_bit_sel, // Bit number for bit access
  input wire logic [port_regs_pkg::DATA_W-1:0] cpu_wdata, // Write data
  input wire logic cpu_rd, // Read strobe
  output logic [port_regs_pkg::DATA_W-1:0] cpu_rdata, // Read data, registered
  output logic cpu_rvalid, // Read data valid pulse
  input wire logic [port_regs_pkg::P3_PINS-1:0] p3_latch, // Port 3 output latch
  output logic [port_regs_pkg::P0_PINS-1:0] oe_p0, // Port 0 output buffer on
  output logic [port_regs_pkg::P1_PINS-1:0] oe_p1, // Port 1 output buffer on
  output logic [port_regs_pkg::P2_PINS-1:0] oe_p2, // Port 2 output buffer on
  output logic [port_regs_pkg::P3_PINS-1:0] oe_p3, // Port 3 output buffer on
  output logic [port_regs_pkg::P5_PINS-1:0] oe_p5, // Port 5 output buffer on
  output logic [port_regs_pkg::P7_PINS-1:0] oe_p7, // Port 7 output buffer on
  output logic [port_regs_pkg::P8_PINS-1:0] oe_p8, // Port 8 output buffer on
  output logic [port_regs_pkg::P9_PINS-1:0] oe_p9, // Port 9 output buffer on
  output logic [port_regs_pkg::P0_PINS-1:0] pu_p0, // Port 0 pull-up connect
  output logic [port_regs_pkg::P1_PINS-1:0] pu_p1, // Port 1 pull-up connect
  output logic [port_regs_pkg::P2_PINS-1:0] pu_p2, // Port 2 pull-up connect
  output logic [port_regs_pkg::P3_PINS-1:0] pu_p3, // Port 3 pull-up connect
  output logic [port_regs_pkg::P7_PINS-1:0] pu_p7, // Port 7 pull-up connect
  output logic [port_regs_pkg::P3_PINS-1:0] ext_irq_req_set // Interrupt request set pulses
);
  import port_regs_pkg::*;

  // Whole register file as one state word
  typedef struct packed {
    logic [7:0] port0_direction; // Port 0 direction
    logic [7:0] port1_direction; // Port 1 direction
    logic [7:0] port2_direction; // Port 2 direction
    logic [7:0] port3_direction; // Port 3 direction
    logic [7:0] port5_direction; // Port 5 direction
    logic [7:0] port7_direction; // Port 7 direction
    logic [7:0] port8_direction; // Port 8 direction
    logic [7:0] port9_direction; // Port 9 direction
    logic [7:0] port01_group_pullup; // Ports 0/1 group pull-up
    logic [7:0] port2_pullup_enable; // Port 2 per-pin pull-up
    logic [7:0] port3_pullup_enable; // Port 3 per-pin pull-up
    logic [7:0] port7_pullup_enable; // Port 7 per-pin pull-up
    logic [7:0] rdata; // Read data holding register
    logic rvalid; // Read answer pulse
  } regs_state_t;

  regs_state_t r_ff; // Current state
  regs_state_t nxt_r; // Next state

  port_cfg_if cfg (); // Settings to the helpers

  // Bit or byte update, then force unbuilt bits to their fixed level
  function automatic logic [7:0] wr_merge(
    input logic [7:0] old_val,
    input logic [7:0] wdata,
    input logic bit_op,
    input logic [2:0] bit_sel,
    input logic [7:0] mask,
    input logic [7:0] fill
  );
    logic [7:0] val;
    val = old_val;
    if (bit_op)
    begin
      val[bit_sel] = wdata[bit_sel]; // Only the addressed bit moves
    end
    else
    begin
      val = wdata; // Whole byte
    end
    return (val & mask) | (fill & ~mask);
  endfunction : wr_merge

  // Read mux; unmapped addresses answer zero
  function automatic logic [7:0] rd_mux(input logic [15:0] addr, input regs_state_t r);
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      OFS_PORT0_DIRECTION: d = r.port0_direction;
      OFS_PORT1_DIRECTION: d = r.port1_direction;
      OFS_PORT2_DIRECTION: d = r.port2_direction;
      OFS_PORT3_DIRECTION: d = r.port3_direction;
      OFS_PORT5_DIRECTION: d = r.port5_direction;
      OFS_PORT7_DIRECTION: d = r.port7_direction;
      OFS_PORT8_DIRECTION: d = r.port8_direction;
      OFS_PORT9_DIRECTION: d = r.port9_direction;
      OFS_PORT01_GROUP_PULLUP: d = r.port01_group_pullup;
      OFS_PORT2_PULLUP_ENABLE: d = r.port2_pullup_enable;
      OFS_PORT3_PULLUP_ENABLE: d = r.port3_pullup_enable;
      OFS_PORT7_PULLUP_ENABLE: d = r.port7_pullup_enable;
      default: d = 8'h00;
    endcase
    return d;
  endfunction : rd_mux

  // Next-state: each register decodes its own address
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.rvalid = cpu_rd;
    if (cpu_rd)
    begin
      nxt_r.rdata = rd_mux(cpu_addr, r_ff);
    end
    if (cpu_wr)
    begin
      // Direction registers: unbuilt bits stay at one
      unique case (cpu_addr)
        OFS_PORT0_DIRECTION:
        begin
          nxt_r.port0_direction = wr_merge(r_ff.port0_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR0_MASK, DIR_RESET);
        end
        OFS_PORT1_DIRECTION:
        begin
          nxt_r.port1_direction = wr_merge(r_ff.port1_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR1_MASK, DIR_RESET);
        end
        OFS_PORT2_DIRECTION:
        begin
          nxt_r.port2_direction = wr_merge(r_ff.port2_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR2_MASK, DIR_RESET);
        end
        OFS_PORT3_DIRECTION:
        begin
          nxt_r.port3_direction = wr_merge(r_ff.port3_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR3_MASK, DIR_RESET);
        end
        OFS_PORT5_DIRECTION:
        begin
          nxt_r.port5_direction = wr_merge(r_ff.port5_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR5_MASK, DIR_RESET);
        end
        OFS_PORT7_DIRECTION:
        begin
          nxt_r.port7_direction = wr_merge(r_ff.port7_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR7_MASK, DIR_RESET);
        end
        OFS_PORT8_DIRECTION:
        begin
          nxt_r.port8_direction = wr_merge(r_ff.port8_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR8_MASK, DIR_RESET);
        end
        OFS_PORT9_DIRECTION:
        begin
          nxt_r.port9_direction = wr_merge(r_ff.port9_direction, cpu_wdata, cpu_bit_op,
            cpu_bit_sel, DIR9_MASK, DIR_RESET);
        end
        // Pull-up options: unbuilt bits stay at zero, so stray ones do nothing
        OFS_PORT01_GROUP_PULLUP:
        begin
          nxt_r.port01_group_pullup = wr_merge(r_ff.port01_group_pullup, cpu_wdata,
            cpu_bit_op, cpu_bit_sel, GRP_PU_MASK, PULLUP_RESET);
        end
        OFS_PORT2_PULLUP_ENABLE:
        begin
          nxt_r.port2_pullup_enable = wr_merge(r_ff.port2_pullup_enable, cpu_wdata,
            cpu_bit_op, cpu_bit_sel, PU2_MASK, PULLUP_RESET);
        end
        OFS_PORT3_PULLUP_ENABLE:
        begin
          nxt_r.port3_pullup_enable = wr_merge(r_ff.port3_pullup_enable, cpu_wdata,
            cpu_bit_op, cpu_bit_sel, PU3_MASK, PULLUP_RESET);
        end
        OFS_PORT7_PULLUP_ENABLE:
        begin
          nxt_r.port7_pullup_enable = wr_merge(r_ff.port7_pullup_enable, cpu_wdata,
            cpu_bit_op, cpu_bit_sel, PU7_MASK, PULLUP_RESET);
        end
        // Writes elsewhere are not ours
        default:
        begin
          nxt_r.rvalid = cpu_rd;
        end
      endcase
    end
  end

  // State register; reset leaves all pins as plain inputs without pull-ups
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_ff.port0_direction <= DIR_RESET;
      r_ff.port1_direction <= DIR_RESET;
      r_ff.port2_direction <= DIR_RESET;
      r_ff.port3_direction <= DIR_RESET;
      r_ff.port5_direction <= DIR_RESET;
      r_ff.port7_direction <= DIR_RESET;
      r_ff.port8_direction <= DIR_RESET;
      r_ff.port9_direction <= DIR_RESET;
      r_ff.port01_group_pullup <= PULLUP_RESET;
      r_ff.port2_pullup_enable <= PULLUP_RESET;
      r_ff.port3_pullup_enable <= PULLUP_RESET;
      r_ff.port7_pullup_enable <= PULLUP_RESET;
      r_ff.rdata <= 8'h00;
      r_ff.rvalid <= 1'b0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // Output buffers on where the direction bit is zero
  always_comb
  begin
    oe_p0 = ~r_ff.port0_direction[P0_PINS-1:0];
    oe_p1 = ~r_ff.port1_direction[P1_PINS-1:0];
    oe_p2 = ~r_ff.port2_direction[P2_PINS-1:0];
    oe_p3 = ~r_ff.port3_direction[P3_PINS-1:0];
    oe_p5 = ~r_ff.port5_direction[P5_PINS-1:0];
    oe_p7 = ~r_ff.port7_direction[P7_PINS-1:0];
    oe_p8 = ~r_ff.port8_direction[P8_PINS-1:0];
    oe_p9 = ~r_ff.port9_direction[P9_PINS-1:0];
  end

  // Settings to the helpers
  assign cfg.dir0 = r_ff.port0_direction;
  assign cfg.dir1 = r_ff.port1_direction;
  assign cfg.dir2 = r_ff.port2_direction;
  assign cfg.dir3 = r_ff.port3_direction;
  assign cfg.dir7 = r_ff.port7_direction;
  assign cfg.grp_pu = r_ff.port01_group_pullup;
  assign cfg.opt2 = r_ff.port2_pullup_enable;
  assign cfg.opt3 = r_ff.port3_pullup_enable;
  assign cfg.opt7 = r_ff.port7_pullup_enable;

  assign cpu_rdata = r_ff.rdata;
  assign cpu_rvalid = r_ff.rvalid;

  // Pull-up connect gating
  pullup_gate u_pullup (
    .cfg (cfg.user),
    .pu_p0 (pu_p0),
    .pu_p1 (pu_p1),
    .pu_p2 (pu_p2),
    .pu_p3 (pu_p3),
    .pu_p7 (pu_p7)
  );

  // Port 3 driven-level change detection; software is expected to mask first
  p3_change_detect u_p3_det (
    .clk (clk),
    .arst_n (arst_n),
    .cfg (cfg.user),
    .p3_latch (p3_latch),
    .irq_set (ext_irq_req_set)
  );

  // Checks, all on the one clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Byte write to a direction register lands with unbuilt bits at one
  a_dir_byte_write: assert property (
    cpu_wr && !cpu_bit_op && cpu_addr == OFS_PORT2_DIRECTION
    |=> r_ff.port2_direction == ($past(cpu_wdata) | ~DIR2_MASK))
    else $error("port 2 direction byte write wrong");

  // Bit write touches only the addressed bit
  a_dir_bit_write: assert property (
    cpu_wr && cpu_bit_op && cpu_addr == OFS_PORT3_DIRECTION && cpu_bit_sel == 3'd1
    |=> r_ff.port3_direction[1] == $past(cpu_wdata[1])
        && r_ff.port3_direction[0] == $past(r_ff.port3_direction[0])
        && r_ff.port3_direction[3:2] == $past(r_ff.port3_direction[3:2]))
    else $error("port 3 direction bit write disturbed other bits");

  // Unbuilt direction bits always read one
  a_dir_unused_ones: assert property (
    r_ff.port0_direction[7:4] == 4'hf && r_ff.port7_direction[7:3] == 5'h1f
    && r_ff.port2_direction[7] && r_ff.port8_direction[7:2] == 6'h3f)
    else $error("unbuilt direction bit not one");

  // Output buffer is the inverse of the direction bit
  a_oe_follows_dir: assert property (
    oe_p3 == ~r_ff.port3_direction[3:0] && oe_p9 == ~r_ff.port9_direction)
    else $error("output enable does not follow direction");

  // Group bit drives all port 0 pins, gated by input mode
  a_group_pullup_p0: assert property (
    pu_p0 == ({4{r_ff.port01_group_pullup[0]}} & r_ff.port0_direction[3:0]))
    else $error("port 0 group pull-up wrong");

  // Group bit 1 drives both port 1 pins
  a_group_pullup_p1: assert property (
    pu_p1 == ({2{r_ff.port01_group_pullup[1]}} & r_ff.port1_direction[1:0]))
    else $error("port 1 group pull-up wrong");

  // Output-mode pin never pulled up
  a_no_pullup_output: assert property (
    !r_ff.port2_direction[4] |-> !pu_p2[4])
    else $error("pull-up on an output pin");

  // Pull-up follows option bit on an input pin
  a_pullup_input: assert property (
    r_ff.port7_direction[2] && r_ff.port7_pullup_enable[2] |-> pu_p7[2])
    else $error("input pin missing pull-up");

  // Unbuilt pull-up bits stay zero even after a byte of ones
  a_pullup_upper_zero: assert property (
    cpu_wr && !cpu_bit_op && cpu_addr == OFS_PORT3_PULLUP_ENABLE && cpu_wdata == 8'hff
    |=> r_ff.port3_pullup_enable == 8'h0f ##1 r_ff.port01_group_pullup[7:2] == 6'h00)
    else $error("unbuilt pull-up bit set");

  // Driven change on port 3 output raises a request next cycle
  a_p3_irq_on_change: assert property (
    !r_ff.port3_direction[0] && !$past(r_ff.port3_direction[0]) && $changed(p3_latch[0])
    |=> ext_irq_req_set[0])
    else $error("port 3 change did not raise request");

  // No request from a pin that was in input mode
  a_p3_no_irq_input: assert property (
    ext_irq_req_set[2]
    |-> !$past(r_ff.port3_direction[2], 1) && !$past(r_ff.port3_direction[2], 2))
    else $error("request from input-mode pin");

  // Read of an unmapped address answers zero one cycle later
  a_read_unmapped: assert property (
    cpu_rd && cpu_addr == 16'hff24 |=> cpu_rvalid && cpu_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Main scenarios
  c_dir_to_output: cover property (cpu_wr && cpu_addr == OFS_PORT3_DIRECTION ##1 oe_p3 != '0);
  c_pullup_on: cover property (pu_p2 != '0);
  c_p3_irq: cover property (ext_irq_req_set != '0);
  c_bit_write_pu: cover property (cpu_wr && cpu_bit_op && cpu_addr == OFS_PORT01_GROUP_PULLUP);

endmodule : port_direction_pullup_regs

// ===== verification/p3_latch_model.sv
`timescale 1ns/1ps
// Stand-in for the port 3 output latch that the change detector watches
module p3_latch_model
  import port_regs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [port_regs_pkg::P3_PINS-1:0] flip, // Pins to invert at next edge
  output logic [port_regs_pkg::P3_PINS-1:0] p3_latch // Latch value into the block
);
  // Latch starts low, so a timer output on a port 3 pin begins idle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p3_latch <= '0;
    end
    else
    begin
      p3_latch <= p3_latch ^ flip; // Level changes come only when the bench asks
    end
  end
endmodule : p3_latch_model

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  import port_regs_pkg::*;
  logic clk = 1'b0; // Bench clock
  logic arst_n = 1'b0; // Reset, active low
  logic [15:0] cpu_addr = 16'h0000; // Bus address
  logic cpu_wr = 1'b0; // Write strobe
  logic cpu_rd = 1'b0; // Read strobe
  logic cpu_bit_op = 1'b0; // Bit access select
  logic [2:0] cpu_bit_sel = 3'h0; // Bit number
  logic [7:0] cpu_wdata = 8'h00; // Write data
  logic [3:0] flip = 4'h0; // Latch toggles for the model
  logic [7:0] cpu_rdata; // Read data
  logic cpu_rvalid; // Read data valid
  logic [3:0] p3_latch, oe_p0, oe_p3, oe_p5, pu_p0, pu_p3, ext_irq_req_set; // Block pins
  logic [1:0] oe_p1, oe_p8, pu_p1; // Two-pin ports
  logic [6:0] oe_p2, pu_p2; // Port 2
  logic [2:0] oe_p7, pu_p7; // Port 7
  logic [7:0] oe_p9; // Port 9
  int bad_count = 0; // Mismatches
  int compares = 0; // Comparisons made
  int cycles = 0; // Hang guard
  logic [15:0] dir_addr [8] = '{OFS_PORT0_DIRECTION, OFS_PORT1_DIRECTION,
    OFS_PORT2_DIRECTION, OFS_PORT3_DIRECTION, OFS_PORT5_DIRECTION,
    OFS_PORT7_DIRECTION, OFS_PORT8_DIRECTION, OFS_PORT9_DIRECTION};
  logic [7:0] dir_mask [8] = '{DIR0_MASK, DIR1_MASK, DIR2_MASK, DIR3_MASK, DIR5_MASK,
    DIR7_MASK, DIR8_MASK, DIR9_MASK};
  logic [15:0] pu_addr [4] = '{OFS_PORT01_GROUP_PULLUP, OFS_PORT2_PULLUP_ENABLE,
    OFS_PORT3_PULLUP_ENABLE, OFS_PORT7_PULLUP_ENABLE};
  logic [7:0] pu_mask [4] = '{GRP_PU_MASK, PU2_MASK, PU3_MASK, PU7_MASK};

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  port_direction_pullup_regs port_direction_pullup_regs_inst (.clk(clk), .arst_n(arst_n),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel),
    .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .p3_latch(p3_latch), .oe_p0(oe_p0), .oe_p1(oe_p1), .oe_p2(oe_p2), .oe_p3(oe_p3),
    .oe_p5(oe_p5), .oe_p7(oe_p7), .oe_p8(oe_p8), .oe_p9(oe_p9), .pu_p0(pu_p0), .pu_p1(pu_p1),
    .pu_p2(pu_p2), .pu_p3(pu_p3), .pu_p7(pu_p7), .ext_irq_req_set(ext_irq_req_set));
  p3_latch_model p3_latch_model_inst (.clk(clk), .arst_n(arst_n), .flip(flip),
    .p3_latch(p3_latch));

  // One comparison, counted, reported at once on mismatch
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Write cycle; the #1 lets the taking edge land before callers look
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b,
    input logic [2:0] s);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_bit_op <= b;
    cpu_bit_sel <= s;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
    #1;
  endtask : wr

  // Read cycle; data and valid are there just after the taking edge, checked at #1
  task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1;
    check("read valid", cpu_rvalid, 1'b1);
    check("read data", cpu_rdata, exp);
  endtask : rd_check

  // Every register at its reset value, no buffer on, no pull-up on
  task automatic reset_values;
    for (int i = 0; i < 8; i++)
      rd_check(dir_addr[i], DIR_RESET);
    for (int i = 0; i < 4; i++)
      rd_check(pu_addr[i], PULLUP_RESET);
    check("oe", {oe_p9, oe_p8, oe_p7, oe_p5, oe_p3, oe_p2, oe_p1, oe_p0}, 34'h0);
    check("pu", {pu_p7, pu_p3, pu_p2, pu_p1, pu_p0}, 20'h0);
  endtask : reset_values

  // Byte writes of zero, then bit writes on a built and an unbuilt bit
  task automatic dir_writes;
    for (int i = 0; i < 8; i++)
      wr(dir_addr[i], 8'h00, 1'b0, 3'h0);
    for (int i = 0; i < 8; i++)
      rd_check(dir_addr[i], ~dir_mask[i]);
    check("oe", {oe_p9, oe_p8, oe_p7, oe_p5, oe_p3, oe_p2, oe_p1, oe_p0}, 34'h3_ffff_ffff);
    wr(OFS_PORT2_DIRECTION, 8'h01, 1'b1, 3'h0);
    wr(OFS_PORT2_DIRECTION, 8'h00, 1'b1, 3'h7);
    rd_check(OFS_PORT2_DIRECTION, 8'h81);
    check("oe port 2", oe_p2, 7'h7e);
  endtask : dir_writes

  // Pull-up options against input-mode gating, group and per-pin
  task automatic pullups;
    for (int i = 0; i < 8; i++)
      wr(dir_addr[i], 8'hff, 1'b0, 3'h0);
    wr(OFS_PORT3_PULLUP_ENABLE, 8'h04, 1'b1, 3'h2);
    rd_check(OFS_PORT3_PULLUP_ENABLE, 8'h04);
    for (int i = 0; i < 4; i++)
      wr(pu_addr[i], (i == 0) ? 8'h03 : 8'hff, 1'b0, 3'h0);
    for (int i = 0; i < 4; i++)
      rd_check(pu_addr[i], pu_mask[i]);
    check("pu", {pu_p7, pu_p3, pu_p2, pu_p1, pu_p0}, 20'hf_ffff);
    wr(OFS_PORT0_DIRECTION, 8'h0e, 1'b0, 3'h0);
    wr(OFS_PORT2_DIRECTION, 8'h00, 1'b0, 3'h0);
    check("pu port 0", pu_p0, 4'he);
    check("pu port 2", pu_p2, 7'h00);
    wr(OFS_PORT01_GROUP_PULLUP, 8'h02, 1'b0, 3'h0);
    check("pu ports 0 1", {pu_p1, pu_p0}, 6'h30);
  endtask : pullups

  // Unmapped place: write lost, read gives zero
  task automatic unmapped;
    wr(16'hff30, 8'h55, 1'b0, 3'h0);
    rd_check(16'hff30, 8'h00);
    rd_check(16'hff24, 8'h00);
  endtask : unmapped

  // Pins 0 and 2 output, pin 1 back to input by a bit write; only outputs request
  task automatic p3_change;
    wr(OFS_PORT3_DIRECTION, 8'hf8, 1'b0, 3'h0);
    wr(OFS_PORT3_DIRECTION, 8'h02, 1'b1, 3'h1);
    check("oe port 3", oe_p3, 4'h5);
    @(posedge clk);
    flip <= 4'h7;
    @(posedge clk);
    flip <= 4'h0;
    @(posedge clk);
    #1;
    check("irq set", ext_irq_req_set, 4'h5);
    @(posedge clk);
    #1;
    check("irq set end", ext_irq_req_set, 4'h0);
  endtask : p3_change

  // Counts, verdict, end of run
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Hang guard: the sequence needs well under 1000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    reset_values();
    dir_writes();
    pullups();
    unmapped();
    p3_change();
    stop_test();
  end
endmodule : tb
